// File: hdl/fcs_regs.svh
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH
// Behaviour
// - switch on each oscillator cycle, off when sense reaches feedback level
// - above start level, begin switching and turn start-up source off
// - below lockout level, stop switching and turn start-up source on
// - while a fault is active, lockout level becomes the recharge level
// - soft start ramps the peak-current threshold up to its maximum
// - supply over-voltage filtered about 20 us; stop while present, resume
// - feedback above overload level counts 8192 cycles, then shut down
// - after overload shutdown, resume once overload condition is gone
// - short circuit shuts down; resume as soon as it clears
// - stop driving when hot; resume only when cooled below lower threshold
// - thermal fault lets supply fall to recharge level, then recharges
// - burst off below burst-low level, resume above burst-high level
// - protect input above threshold shuts down; resume once it clears
// - peak-current threshold clamped at its internal maximum
// - current-limit comparator ignored about 350 ns after turn-on
// - short-circuit comparator ignored about 300 ns after turn-on
// - period jitter plus or minus 4 percent over 256 periods
`define FCS_CTRL_OFS     8'h00
`define FCS_PERIOD_OFS   8'h04
`define FCS_STATUS_OFS   8'h08
`define FCS_IRQ_STAT_OFS 8'h0C
`define FCS_IRQ_MASK_OFS 8'h10
`define FCS_CTRL_EN_BIT  0
`define FCS_CTRL_RST     1'b1
`define FCS_PERIOD_RST   16'h00C8
`define FCS_MASK_RST     8'h00
`define FCS_ST_STATE_LSB 0
`define FCS_ST_FAULT_LSB 2
`define FCS_ST_BURST_BIT 7
`define FCS_ST_GATE_BIT  8
`define FCS_ST_HV_BIT    9
`define FCS_EV_START 0
`define FCS_EV_LOCK  1
`define FCS_EV_SCP   2
`define FCS_EV_OLP   3
`define FCS_EV_OVP   4
`define FCS_EV_OTP   5
`define FCS_EV_PRO   6
`define FCS_EV_BURST 7
`define FCS_CLK_NS      50
`define FCS_LEB1_NS     350
`define FCS_LEB2_NS     300
`define FCS_OVP_FILT_NS 20000
`define FCS_LEB1_CYC ((`FCS_LEB1_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_LEB2_CYC ((`FCS_LEB2_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_OVP_FILT_CYC \
  ((`FCS_OVP_FILT_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_OLP_CYCLES  8192
`define FCS_JIT_PCT     4
`define FCS_JIT_DIV     (100 * 64 / `FCS_JIT_PCT)
`define FCS_SS_STEP_CYC 64
`define FCS_SS_MAX      8'hFF
`endif

// File: hdl/fcs_pkg.sv
package fcs_pkg;
  typedef enum logic [1:0] {
    fcs_st_charge = 2'b00,
    fcs_st_run    = 2'b01,
    fcs_st_fault  = 2'b11
  } fcs_state_t;

  // analog comparator outputs, all active high
  typedef struct packed {
    logic above_start;
    logic below_stop;
    logic below_recharge;
    logic supply_over;
    logic fb_overload;
    logic fb_burst_low;
    logic fb_burst_high;
    logic sense_fb;
    logic sense_limit;
    logic sense_short;
    logic temp_hot;
    logic temp_cool;
    logic protect;
  } fcs_cmp_t;

  typedef struct packed {
    logic pro;
    logic otp;
    logic supply_overvoltage_fault;
    logic overload_fault;
    logic short_circuit_fault;
  } fcs_fault_t;
endpackage

// File: hdl/fcs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "fcs_regs.svh"
module fcs_sequencer
  import fcs_pkg::*;
#(
  parameter int OLP_CYCLES = `FCS_OLP_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire fcs_cmp_t    cmp_in,
  output logic             gate_drive,
  output logic             hv_source_on,
  output logic [7:0]       sense_limit_level,
  output logic             irq
);
  localparam logic [3:0]  LEB1 = 4'(`FCS_LEB1_CYC);
  localparam logic [3:0]  LEB2 = 4'(`FCS_LEB2_CYC);
  localparam logic [8:0]  OVP_FILT = 9'(`FCS_OVP_FILT_CYC);
  localparam logic [13:0] OLP_CNT = 14'(OLP_CYCLES);
  localparam logic [5:0]  SS_STEP = 6'(`FCS_SS_STEP_CYC - 1);
  localparam logic signed [26:0] JIT_DIV = 27'(`FCS_JIT_DIV);

  ////////////////////////////////////////////////////////////////////////
  // synchroniser, bus and registers
  fcs_cmp_t    cmp_meta, cmp;
  logic        wr_pend, next_wr_pend;
  logic [7:0]  wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic        ctrl_en, next_ctrl_en;
  logic [15:0] period, next_period;
  logic [7:0]  irq_stat, next_irq_stat;
  logic [7:0]  irq_mask, next_irq_mask;
  logic        next_irq;
  logic [7:0]  ev;
  logic [31:0] status;
  logic        acc;

  fcs_state_t  state, next_state;
  fcs_fault_t  fault, next_fault;
  logic        any_fault, burst_off, next_burst_off;

  assign hreadyout = clk_en;
  assign hresp     = 1'b0;
  assign acc       = hsel & hready & htrans[1];
  assign any_fault = |fault;

  always_comb begin
    status = 32'h0000_0000;
    status[`FCS_ST_STATE_LSB +: 2] = state;
    status[`FCS_ST_FAULT_LSB +: 5] = fault;
    status[`FCS_ST_BURST_BIT]      = burst_off;
    status[`FCS_ST_GATE_BIT]       = gate_drive;
    status[`FCS_ST_HV_BIT]         = hv_source_on;
  end

  always_comb begin
    next_wr_pend  = acc & hwrite;
    next_wr_addr  = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
    next_hrdata   = hrdata;
    next_ctrl_en  = ctrl_en;
    next_period   = period;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (acc && !hwrite) begin
      next_hrdata = 32'h0000_0000;
      unique case (next_wr_addr)
        `FCS_CTRL_OFS:     next_hrdata[`FCS_CTRL_EN_BIT] = ctrl_en;
        `FCS_PERIOD_OFS:   next_hrdata[15:0] = period;
        `FCS_STATUS_OFS:   next_hrdata = status;
        `FCS_IRQ_STAT_OFS: next_hrdata[7:0] = irq_stat;
        `FCS_IRQ_MASK_OFS: next_hrdata[7:0] = irq_mask;
        default:           next_hrdata = 32'h0000_0000;
      endcase
    end
    if (wr_pend) begin
      unique case (wr_addr)
        `FCS_CTRL_OFS:     next_ctrl_en = hwdata[`FCS_CTRL_EN_BIT];
        `FCS_PERIOD_OFS:   next_period = hwdata[15:0];
        `FCS_IRQ_STAT_OFS: next_irq_stat = irq_stat & ~hwdata[7:0];
        `FCS_IRQ_MASK_OFS: next_irq_mask = hwdata[7:0];
        default: ;
      endcase
    end
    // an event in the clearing cycle survives
    next_irq_stat = next_irq_stat | ev;
    next_irq      = |(irq_stat & irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_meta <= '0;
      cmp      <= '0;
      wr_pend  <= 1'b0;
      wr_addr  <= 8'h00;
      hrdata   <= 32'h0000_0000;
      ctrl_en  <= `FCS_CTRL_RST;
      period   <= `FCS_PERIOD_RST;
      irq_stat <= 8'h00;
      irq_mask <= `FCS_MASK_RST;
      irq      <= 1'b0;
    end else if (clk_en) begin
      cmp_meta <= cmp_in;
      cmp      <= cmp_meta;
      wr_pend  <= next_wr_pend;
      wr_addr  <= next_wr_addr;
      hrdata   <= next_hrdata;
      ctrl_en  <= next_ctrl_en;
      period   <= next_period;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq      <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator with triangular period jitter
  logic [17:0]        per_cnt, next_per_cnt;
  logic [7:0]         jit_cnt, next_jit_cnt;
  logic [6:0]         tri_pos;
  logic signed [17:0] base_s, period_eff;
  logic signed [8:0]  tri_s;
  logic signed [26:0] dev, offs;
  logic               tick;

  always_comb begin
    tri_pos    = jit_cnt[7] ? ~jit_cnt[6:0] : jit_cnt[6:0];
    base_s     = {2'b00, period};
    tri_s      = $signed({2'b00, tri_pos}) - 9'sd64;
    dev        = base_s * tri_s;
    offs       = dev / JIT_DIV;
    period_eff = base_s + offs[17:0];
    tick       = per_cnt >= ($unsigned(period_eff) - 18'd1);
    next_per_cnt = tick ? 18'd0 : per_cnt + 18'd1;
    next_jit_cnt = tick ? jit_cnt + 8'd1 : jit_cnt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_cnt <= 18'd0;
      jit_cnt <= 8'h00;
    end else if (clk_en) begin
      per_cnt <= next_per_cnt;
      jit_cnt <= next_jit_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // supply sequencing, faults, burst
  logic        thr_low;
  logic [13:0] olp_cnt, next_olp_cnt;
  logic [8:0]  ovp_cnt, next_ovp_cnt;
  logic        next_hv;
  logic        gate_on, next_gate;
  logic [3:0]  on_cnt, next_on_cnt;
  logic        allowed;

  always_comb begin
    // a fault drops the lockout level to the recharge level
    thr_low    = any_fault ? cmp.below_recharge : cmp.below_stop;
    next_state = state;
    unique case (state)
      fcs_st_charge:
        if (cmp.above_start) next_state = fcs_st_run;
      fcs_st_run:
        if (thr_low) next_state = fcs_st_charge;
        else if (any_fault) next_state = fcs_st_fault;
      fcs_st_fault:
        // discharge then recharge, or resume when the fault is gone
        if (thr_low) next_state = fcs_st_charge;
        else if (!any_fault) next_state = fcs_st_run;
      default: next_state = fcs_st_charge;
    endcase
    next_hv = next_state == fcs_st_charge;

    next_fault = fault;
    if (!cmp.sense_short) next_fault.short_circuit_fault = 1'b0;
    if (gate_on && on_cnt >= LEB2 && cmp.sense_short)
      next_fault.short_circuit_fault = 1'b1;
    next_olp_cnt = olp_cnt;
    if (!cmp.fb_overload) next_olp_cnt = 14'd0;
    else if (tick && olp_cnt != OLP_CNT)
      next_olp_cnt = olp_cnt + 14'd1;
    next_fault.overload_fault = cmp.fb_overload &
                     (fault.overload_fault | olp_cnt == OLP_CNT);
    // debounce both ways, acts as the filter time constant
    next_ovp_cnt = 9'd0;
    if (cmp.supply_over != fault.supply_overvoltage_fault) begin
      next_ovp_cnt = ovp_cnt + 9'd1;
      if (ovp_cnt == OVP_FILT - 9'd1) begin
        next_ovp_cnt   = 9'd0;
        next_fault.supply_overvoltage_fault = cmp.supply_over;
      end
    end
    if (cmp.temp_cool) next_fault.otp = 1'b0;
    if (cmp.temp_hot) next_fault.otp = 1'b1;
    next_fault.pro = cmp.protect;

    next_burst_off = burst_off;
    if (cmp.fb_burst_high) next_burst_off = 1'b0;
    if (cmp.fb_burst_low) next_burst_off = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state        <= fcs_st_charge;
      hv_source_on <= 1'b1;
      fault        <= '0;
      olp_cnt      <= 14'd0;
      ovp_cnt      <= 9'd0;
      burst_off    <= 1'b0;
    end else if (clk_en) begin
      state        <= next_state;
      hv_source_on <= next_hv;
      fault        <= next_fault;
      olp_cnt      <= next_olp_cnt;
      ovp_cnt      <= next_ovp_cnt;
      burst_off    <= next_burst_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // switch drive, blanking and soft start
  logic [7:0] ss_level, next_ss_level;
  logic [5:0] ss_div, next_ss_div;
  logic       run_entry;

  assign gate_drive        = gate_on;
  assign sense_limit_level = ss_level;

  always_comb begin
    allowed = state == fcs_st_run && !any_fault && !burst_off &&
              ctrl_en;
    next_gate   = gate_on;
    next_on_cnt = (gate_on && on_cnt != 4'hF) ? on_cnt + 4'd1 : on_cnt;
    if (!allowed) begin
      next_gate = 1'b0;
    end else if (tick) begin
      next_gate   = 1'b1;
      next_on_cnt = 4'd0;
    end else if (gate_on && on_cnt >= LEB1 &&
                 (cmp.sense_fb || cmp.sense_limit)) begin
      next_gate = 1'b0;
    end

    run_entry     = state == fcs_st_charge && next_state == fcs_st_run;
    next_ss_level = ss_level;
    next_ss_div   = ss_div;
    if (run_entry) begin
      next_ss_level = 8'h00;
      next_ss_div   = 6'd0;
    end else if (state == fcs_st_run && ss_level != `FCS_SS_MAX) begin
      next_ss_div = ss_div + 6'd1;
      if (ss_div == SS_STEP) begin
        next_ss_div   = 6'd0;
        next_ss_level = ss_level + 8'd1;
      end
    end

    ev = 8'h00;
    ev[`FCS_EV_START] = run_entry;
    ev[`FCS_EV_LOCK]  = state != fcs_st_charge &&
                        next_state == fcs_st_charge;
    ev[`FCS_EV_SCP]   = next_fault.short_circuit_fault & ~fault.short_circuit_fault;
    ev[`FCS_EV_OLP]   = next_fault.overload_fault & ~fault.overload_fault;
    ev[`FCS_EV_OVP]   = next_fault.supply_overvoltage_fault & ~fault.supply_overvoltage_fault;
    ev[`FCS_EV_OTP]   = next_fault.otp & ~fault.otp;
    ev[`FCS_EV_PRO]   = next_fault.pro & ~fault.pro;
    ev[`FCS_EV_BURST] = next_burst_off & ~burst_off;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_on  <= 1'b0;
      on_cnt   <= 4'd0;
      ss_level <= 8'h00;
      ss_div   <= 6'd0;
    end else if (clk_en) begin
      gate_on  <= next_gate;
      on_cnt   <= next_on_cnt;
      ss_level <= next_ss_level;
      ss_div   <= next_ss_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking ck @(posedge hclk); endclocking
  default disable iff (!hresetn);

  gate_on_tick_a: assert property (
    clk_en && tick && allowed |=> gate_drive && on_cnt == 4'd0)
    else $error("drive not on at cycle start");
  start_hv_off_a: assert property (
    clk_en && state == fcs_st_charge && cmp.above_start
    |=> state == fcs_st_run && !hv_source_on)
    else $error("start level did not begin switching");
  lockout_stop_a: assert property (
    clk_en && state == fcs_st_run && !any_fault && cmp.below_stop
    |=> state == fcs_st_charge && hv_source_on ##1 !gate_drive)
    else $error("lockout did not stop switching");
  fault_thr_a: assert property (
    clk_en && state == fcs_st_fault && any_fault &&
    !cmp.below_recharge |=> state != fcs_st_charge)
    else $error("fault lockout used stop level");
  blank_cl_a: assert property (
    clk_en && gate_drive && on_cnt < LEB1 && allowed && !tick
    |=> gate_drive)
    else $error("pulse ended inside blanking");
  blank_sc_a: assert property (
    clk_en && gate_drive && on_cnt < LEB2 && !fault.short_circuit_fault
    |=> !fault.short_circuit_fault)
    else $error("short circuit seen inside blanking");
  olp_trip_a: assert property (
    clk_en && olp_cnt == OLP_CNT && cmp.fb_overload
    |=> fault.overload_fault ##1 !gate_drive)
    else $error("overload did not shut down");
  olp_clear_a: assert property (
    clk_en && !cmp.fb_overload |=> olp_cnt == 14'd0 && !fault.overload_fault)
    else $error("overload count not cleared");
  gate_low_a: assert property (
    clk_en && (state != fcs_st_run || any_fault || burst_off)
    |=> !gate_drive)
    else $error("drive high while inhibited");
  burst_hold_a: assert property (
    clk_en && burst_off && !cmp.fb_burst_high |=> burst_off)
    else $error("burst left below high level");
  ovp_filt_a: assert property (
    clk_en && !fault.supply_overvoltage_fault && ovp_cnt < OVP_FILT - 9'd1 |=> !fault.supply_overvoltage_fault)
    else $error("over-voltage passed filter early");
  scp_clear_a: assert property (
    clk_en && !cmp.sense_short |=> !fault.short_circuit_fault)
    else $error("short circuit flag outlived its cause");
  otp_hold_a: assert property (
    clk_en && fault.otp && !cmp.temp_cool |=> fault.otp)
    else $error("thermal fault released while still hot");
  pro_trip_a: assert property (
    clk_en && cmp.protect |=> fault.pro)
    else $error("protect input did not shut down");
  resume_run_a: assert property (
    clk_en && state == fcs_st_fault && !any_fault && !thr_low
    |=> state == fcs_st_run)
    else $error("no resume after faults cleared");
  supply_recharge_a: assert property (
    clk_en && state == fcs_st_fault && any_fault && cmp.below_recharge
    |=> state == fcs_st_charge && hv_source_on)
    else $error("fault did not recharge the supply");
  ss_restart_a: assert property (
    clk_en && run_entry |=> sense_limit_level == 8'h00)
    else $error("soft start did not begin at zero");
  ss_clamp_a: assert property (
    clk_en && state == fcs_st_run
    |=> sense_limit_level >= $past(sense_limit_level))
    else $error("peak threshold wrapped past its maximum");

  // bound of the jitter, worked out apart from the divider it guards
  logic [17:0] jit_span;
  assign jit_span = {2'b00, period} / 18'(100 / `FCS_JIT_PCT);
  jitter_span_a: assert property (
    clk_en |-> $unsigned(period_eff) <= {2'b00, period} + jit_span &&
               $unsigned(period_eff) + jit_span >= {2'b00, period})
    else $error("period jitter beyond its span");

  run_cover_c:   cover property (clk_en && ev[`FCS_EV_START]);
  otp_cover_c:   cover property (clk_en && ev[`FCS_EV_OTP]);
  olp_cover_c:   cover property (clk_en && ev[`FCS_EV_OLP]);
  burst_cover_c: cover property (burst_off ##1 !burst_off);
endmodule // fcs_sequencer
`default_nettype wire

// File: test/fcs_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module fcs_far_model
  import fcs_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       gate_drive,
  input  wire fcs_cmp_t   env,
  input  wire logic [7:0] sense_delay,
  output var fcs_cmp_t    cmp_out
);
  logic [7:0] on_cyc;
  logic [7:0] next_on_cyc;

  // current ramps only while the switch conducts
  always_comb begin
    next_on_cyc = (gate_drive && on_cyc != 8'hFF) ? on_cyc + 8'h01 : 8'h00;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) on_cyc <= 8'h00;
    else          on_cyc <= next_on_cyc;
  end

  always_comb begin
    cmp_out = env;
    cmp_out.sense_fb = gate_drive && (on_cyc >= sense_delay);
  end
endmodule // fcs_far_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "fcs_regs.svh"
module tb_top
  import fcs_pkg::*;
;
  localparam int LIMIT = 20000;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_pend;
  logic        gate_drive, hv_source_on, irq, clk_en;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  sense_limit_level, sense_delay, lv0;
  fcs_cmp_t    env, cmp_in;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          miscompares, compares, cyc;

  fcs_sequencer #(.OLP_CYCLES(4)) fcs_sequencer_i (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cmp_in(cmp_in),
    .gate_drive(gate_drive), .hv_source_on(hv_source_on),
    .sense_limit_level(sense_limit_level), .irq(irq));

  fcs_far_model fcs_far_model_i (
    .hclk(hclk), .hresetn(hresetn), .gate_drive(gate_drive), .env(env),
    .sense_delay(sense_delay), .cmp_out(cmp_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, msk);
    compares++;
    if ((got & msk) !== (exp & msk)) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_width(input int got, lo, hi);
    compares++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // read: d is the expected word, noted for the monitor
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, m);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h00000000;
    rd_pend <= !w;
    if (!w) begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_pend <= 1'b0;
  endtask

  task automatic pulse(input int lo, hi);
    int n;
    n = 0;
    // let a pulse already under way finish before measuring
    while (gate_drive === 1'b1 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    n = 0;
    while (gate_drive !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    n = 0;
    while (gate_drive === 1'b1 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    chk_width(n, lo, hi);
  endtask

  task automatic no_gate(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      @(posedge hclk);
      if (gate_drive !== 1'b0) hits++;
    end
    chk(hits, 0, 32'hFFFFFFFF);
  endtask

  always @(posedge hclk) begin
    if (rd_pend === 1'b1 && hreadyout === 1'b1 && exp_q.size() > 0)
      chk(hrdata, exp_q.pop_front(), msk_q.pop_front());
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] p;
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; rd_pend = 1'b0;
    haddr = 32'h0; hwdata = 32'h0; htrans = 2'b00; hsize = 3'h2;
    clk_en = 1'b1; env = '0; sense_delay = 8'h00;
    miscompares = 0; compares = 0; cyc = 0;
    void'($urandom(32'hF9981967));
    tick(20);
    hresetn <= 1'b1;
    tick(1);
    chk({31'h0, gate_drive}, 32'h0, 32'h1);
    chk({31'h0, hv_source_on}, 32'h1, 32'h1);
    chk({31'h0, hresp}, 32'h0, 32'h1);
    bus(0, `FCS_CTRL_OFS, 32'h1, 32'h1);
    bus(0, `FCS_PERIOD_OFS, 32'(`FCS_PERIOD_RST), 32'hFFFF);
    bus(0, `FCS_IRQ_MASK_OFS, 32'(`FCS_MASK_RST), 32'hFF);
    bus(1, 8'h40, $urandom, 32'h0);
    bus(0, 8'h40, 32'h0, 32'hFFFFFFFF);
    p = 16'h0010 + 16'($urandom_range(200));
    bus(1, `FCS_PERIOD_OFS, {16'h0, p}, 32'h0);
    bus(0, `FCS_PERIOD_OFS, {16'h0, p}, 32'hFFFF);
    bus(1, `FCS_PERIOD_OFS, 32'h28, 32'h0);
    env.above_start <= 1'b1;
    tick(6);
    lv0 = sense_limit_level;
    chk({31'h0, hv_source_on}, 32'h0, 32'h1);
    bus(0, `FCS_STATUS_OFS, 32'h1, 32'h3);
    pulse(8, 8);
    sense_delay <= 8'd20;
    pulse(21, 25);
    sense_delay <= 8'hFF;
    env.sense_limit <= 1'b1;
    pulse(8, 8);
    env.sense_limit <= 1'b0;
    sense_delay <= 8'd0;
    chk({31'h0, sense_limit_level > lv0}, 32'h1, 32'h1);
    // clock enable low must freeze the ramp and stall the bus
    clk_en <= 1'b0;
    tick(3);
    lv0 = sense_limit_level;
    tick(150);
    chk({24'h0, sense_limit_level}, {24'h0, lv0}, 32'hFF);
    chk({31'h0, hreadyout}, 32'h0, 32'h1);
    clk_en <= 1'b1;
    env.sense_short <= 1'b1;
    tick(100);
    bus(0, `FCS_STATUS_OFS, 32'h07, 32'h7F);
    no_gate(100);
    env.sense_short <= 1'b0;
    tick(100);
    bus(0, `FCS_STATUS_OFS, 32'h01, 32'h7F);
    bus(0, `FCS_IRQ_STAT_OFS, 32'h05, 32'h05);
    chk({31'h0, irq}, 32'h0, 32'h1);
    bus(1, `FCS_IRQ_MASK_OFS, 32'h04, 32'h0);
    tick(3);
    chk({31'h0, irq}, 32'h1, 32'h1);
    bus(1, `FCS_IRQ_STAT_OFS, 32'h04, 32'h0);
    tick(3);
    chk({31'h0, irq}, 32'h0, 32'h1);
    bus(1, `FCS_IRQ_MASK_OFS, 32'h00, 32'h0);
    bus(1, `FCS_CTRL_OFS, 32'h0, 32'h0);
    tick(2);
    no_gate(100);
    bus(1, `FCS_CTRL_OFS, 32'h1, 32'h0);
    // protect, filtered over-voltage, overload in turn
    for (int i = 0; i < 3; i++) begin
      env.protect <= (i == 0);
      env.supply_over <= (i == 1);
      env.fb_overload <= (i == 2);
      tick(600);
      bus(0, `FCS_STATUS_OFS, (i == 0) ? 32'h43 : (i == 1) ? 32'h13 : 32'h0B,
          32'h7F);
      no_gate(60);
      env <= '{above_start: 1'b1, default: 1'b0};
      tick(600);
      bus(0, `FCS_STATUS_OFS, 32'h01, 32'h7F);
    end
    // short overload bursts must not add up
    repeat (2) begin
      env.fb_overload <= 1'b1;
      tick(90);
      env.fb_overload <= 1'b0;
      tick(20);
    end
    bus(0, `FCS_STATUS_OFS, 32'h01, 32'h7F);
    env.temp_hot <= 1'b1;
    tick(10);
    env.temp_hot <= 1'b0;
    tick(10);
    bus(0, `FCS_STATUS_OFS, 32'h23, 32'h7F);
    env.above_start <= 1'b0;
    env.below_stop <= 1'b1;
    tick(10);
    bus(0, `FCS_STATUS_OFS, 32'h23, 32'h7F);
    env.below_recharge <= 1'b1;
    tick(10);
    bus(0, `FCS_STATUS_OFS, 32'h00, 32'h03);
    chk({31'h0, hv_source_on}, 32'h1, 32'h1);
    env <= '{above_start: 1'b1, temp_cool: 1'b1, default: 1'b0};
    tick(10);
    bus(0, `FCS_STATUS_OFS, 32'h01, 32'h7F);
    env.temp_cool <= 1'b0;
    env.fb_burst_low <= 1'b1;
    tick(10);
    bus(0, `FCS_STATUS_OFS, 32'h80, 32'h80);
    no_gate(150);
    env.fb_burst_low <= 1'b0;
    no_gate(100);
    env.fb_burst_high <= 1'b1;
    pulse(8, 8);
    bus(0, `FCS_STATUS_OFS, 32'h00, 32'h80);
    env.below_stop <= 1'b1;
    env.above_start <= 1'b0;
    tick(10);
    bus(0, `FCS_STATUS_OFS, 32'h00, 32'h03);
    chk({31'h0, hv_source_on}, 32'h1, 32'h1);
    no_gate(100);
    tick(4);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
